/* File: src/uart_ier_pkg.sv */
// Register map, field positions and reset values of the interrupt enable block.
`default_nettype none
package uart_ier_pkg;
  localparam logic [31:0] ier_dlm_addr     = 32'he000c004;
  localparam logic [31:0] dll_addr         = 32'he000c000;
  localparam logic [31:0] lcr_addr         = 32'he000c00c;
  localparam logic [31:0] fdr_addr         = 32'he000c028;
  localparam logic [31:0] lsr_addr         = 32'he000c014;
  localparam logic [31:0] evt_status_addr  = 32'he000c040;
  localparam logic [31:0] evt_mask_addr    = 32'he000c044;
  localparam logic [31:0] baud_cnt_addr    = 32'he000c048;
  localparam int          rda_bit          = 0;
  localparam int          transmit_holding_empty_bit         = 1;
  localparam int          rls_bit          = 2;
  localparam int          abto_bit         = 8;
  localparam int          abeo_bit         = 9;
  localparam int          ier_w            = 10;
  localparam int          divisor_latch_access_bit_bit         = 7;
  localparam int          lsr_transmit_holding_empty_bit     = 5;
  localparam int          lsr_err_lo       = 1;
  localparam int          lsr_err_hi       = 4;
  localparam int          oversample       = 16;
  localparam int          n_src            = 5;
  localparam logic [9:0]  ier_valid_mask   = 10'h307;
  localparam logic [9:0]  ier_reset        = 10'h000;
  localparam logic [7:0]  dlm_reset        = 8'h00;
  localparam logic [7:0]  dll_reset        = 8'h01;
  localparam logic [3:0]  divadd_reset     = 4'h0;
  localparam logic [3:0]  mul_reset        = 4'h1;
  localparam logic [7:0]  lcr_reset        = 8'h03;
  localparam int          fdr_add_lo       = 0;
  localparam int          fdr_mul_lo       = 4;
  // Event bit positions in the sticky status and mask registers.
  localparam int          ev_rda           = 0;
  localparam int          ev_transmit_holding_empty          = 1;
  localparam int          ev_rls           = 2;
  localparam int          ev_abto          = 3;
  localparam int          ev_abeo          = 4;
endpackage
`default_nettype wire

/* File: src/baud_tick_gen.sv */
// Baud tick generator: 16-bit divisor with fractional prescaler.
`default_nettype none
module baud_tick_gen
(
  input  wire logic        clk_sys,
  input  wire logic        srst,
  input  wire logic [15:0] divisor,
  input  wire logic [3:0]  frac_add,
  input  wire logic [3:0]  frac_mul,
  output logic             tick_16x
);
  logic [15:0] cnt_ff;
  logic [4:0]  acc_ff;
  logic        hold_ff;
  logic [4:0]  acc_sum;
  logic        wrap;

  assign acc_sum = acc_ff + {1'b0, frac_add};
  assign wrap    = (cnt_ff <= 16'h0001);

  // A divisor period is stretched by one extra period whenever the
  // fractional accumulator overflows, giving mul/(mul+add) scaling.
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      cnt_ff   <= 16'h0000;
      acc_ff   <= 5'h00;
      hold_ff  <= 1'b0;
      tick_16x <= 1'b0;
    end
    else
    begin
      tick_16x <= 1'b0;
      if (divisor == 16'h0000)
        cnt_ff <= 16'h0000;
      else if (wrap)
      begin
        cnt_ff <= divisor;
        if (hold_ff)
          hold_ff <= 1'b0;
        else if (frac_add != 4'h0 && frac_mul != 4'h0
                 && acc_sum >= {1'b0, frac_mul})
        begin
          acc_ff  <= acc_sum - {1'b0, frac_mul};
          hold_ff <= 1'b1;
          tick_16x <= 1'b1;
        end
        else
        begin
          if (frac_add != 4'h0)
            acc_ff <= acc_sum;
          tick_16x <= 1'b1;
        end
      end
      else
        cnt_ff <= cnt_ff - 16'h0001;
    end
  end
endmodule
`default_nettype wire

/* File: src/irq_gate.sv */
// Gates pending interrupt sources with their enable bits.
`default_nettype none
module irq_gate
(
  input  wire logic       clk_sys,
  input  wire logic       srst,
  input  wire logic [4:0] pending,
  input  wire logic [4:0] enable,
  output logic [4:0]      active,
  output logic            any_active
);
  genvar i;
  generate
    for (i = 0; i < 5; i++)
    begin : g_src
      always_ff @(posedge clk_sys)
      begin
        if (srst)
          active[i] <= 1'b0;
        else
          active[i] <= pending[i] & enable[i];
      end
    end
  endgenerate

  always_ff @(posedge clk_sys)
  begin
    if (srst)
      any_active <= 1'b0;
    else
      any_active <= |(pending & enable);
  end
endmodule
`default_nettype wire

/* File: src/uart_interrupt_enable.sv */
// Interrupt source enable register, divisor latch and event logic.
`default_nettype none
module uart_interrupt_enable
(
  input  wire logic        clk_sys,
  input  wire logic        srst,
  input  wire logic [31:0] addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr_en,
  input  wire logic        rd_en,
  output logic      [31:0] rdata,
  input  wire logic        receive_data_available,
  input  wire logic        char_timeout,
  input  wire logic        transmit_holding_empty,
  input  wire logic [3:0]  rx_line_errors,
  input  wire logic        autobaud_timeout,
  input  wire logic        autobaud_done,
  output logic             irq,
  output logic             event_irq,
  output logic             baud_tick_16x
);
  ////////////////////////////////////////////////////////////////////////////
  logic [9:0]  interrupt_source_enable_ff;
  logic [7:0]  divisor_high_byte_ff;
  logic [7:0]  divisor_low_byte_ff;
  logic [7:0]  line_ctrl_ff;
  logic [3:0]  fractional_add_value_ff;
  logic [3:0]  fractional_multiplier_ff;
  logic [4:0]  evt_status_ff;
  logic [4:0]  evt_mask_ff;
  logic [4:0]  src_prev_ff;
  logic [15:0] tick_cnt_ff;
  logic [4:0]  pending;
  logic [4:0]  enable;
  logic [4:0]  active;
  logic        any_active;
  logic [4:0]  rise;
  logic [4:0]  nxt_evt_status;
  logic        divisor_latch_access_bit;
  logic [15:0] divisor;
  logic        tick;
  logic [31:0] nxt_rdata;

  function automatic logic hit(input logic [31:0] a, input logic [31:0] r);
    hit = (a == r);
  endfunction

  assign divisor_latch_access_bit = line_ctrl_ff[uart_ier_pkg::divisor_latch_access_bit_bit];
  assign divisor = {divisor_high_byte_ff, divisor_low_byte_ff};

  ////////////////////////////////////////////////////////////////////////////
  // Source pending vector and enable vector, in event bit order.
  always_comb
  begin
    pending = 5'h00;
    pending[uart_ier_pkg::ev_rda]  = receive_data_available
                                   | char_timeout;
    pending[uart_ier_pkg::ev_transmit_holding_empty] = transmit_holding_empty;
    pending[uart_ier_pkg::ev_rls]  = |rx_line_errors;
    pending[uart_ier_pkg::ev_abto] = autobaud_timeout;
    pending[uart_ier_pkg::ev_abeo] = autobaud_done;
    enable = 5'h00;
    enable[uart_ier_pkg::ev_rda] =
      interrupt_source_enable_ff[uart_ier_pkg::rda_bit];
    enable[uart_ier_pkg::ev_transmit_holding_empty] =
      interrupt_source_enable_ff[uart_ier_pkg::transmit_holding_empty_bit];
    enable[uart_ier_pkg::ev_rls] =
      interrupt_source_enable_ff[uart_ier_pkg::rls_bit];
    enable[uart_ier_pkg::ev_abto] =
      interrupt_source_enable_ff[uart_ier_pkg::abto_bit];
    enable[uart_ier_pkg::ev_abeo] =
      interrupt_source_enable_ff[uart_ier_pkg::abeo_bit];
  end

  irq_gate u_irq_gate
  (
    .clk_sys    (clk_sys),
    .srst       (srst),
    .pending    (pending),
    .enable     (enable),
    .active     (active),
    .any_active (any_active)
  );

  assign irq = any_active;

  baud_tick_gen u_baud
  (
    .clk_sys  (clk_sys),
    .srst     (srst),
    .divisor  (divisor),
    .frac_add (fractional_add_value_ff),
    .frac_mul (fractional_multiplier_ff),
    .tick_16x (tick)
  );

  // Each sixteenth oversample tick is one bit time.
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      tick_cnt_ff   <= 16'h0000;
      baud_tick_16x <= 1'b0;
    end
    else
    begin
      baud_tick_16x <= tick;
      if (tick)
        tick_cnt_ff <= tick_cnt_ff + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Enable register and divisor high byte share one address.
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      interrupt_source_enable_ff <= uart_ier_pkg::ier_reset;
      divisor_high_byte_ff       <= uart_ier_pkg::dlm_reset;
    end
    else if (wr_en && hit(addr, uart_ier_pkg::ier_dlm_addr))
    begin
      if (!divisor_latch_access_bit)
        interrupt_source_enable_ff <= wdata[9:0]
                                      & uart_ier_pkg::ier_valid_mask;
      else
        divisor_high_byte_ff <= wdata[7:0];
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      divisor_low_byte_ff      <= uart_ier_pkg::dll_reset;
      line_ctrl_ff             <= uart_ier_pkg::lcr_reset;
      fractional_add_value_ff  <= uart_ier_pkg::divadd_reset;
      fractional_multiplier_ff <= uart_ier_pkg::mul_reset;
    end
    else if (wr_en)
    begin
      if (hit(addr, uart_ier_pkg::dll_addr) && divisor_latch_access_bit)
        divisor_low_byte_ff <= wdata[7:0];
      else if (hit(addr, uart_ier_pkg::lcr_addr))
        line_ctrl_ff <= wdata[7:0];
      else if (hit(addr, uart_ier_pkg::fdr_addr))
      begin
        fractional_add_value_ff  <= wdata[3:0];
        fractional_multiplier_ff <= wdata[7:4];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sticky event status: rising source edges set, write-one clears,
  // and a set in the same cycle as its clear wins.
  assign rise = pending & ~src_prev_ff;

  always_comb
  begin
    nxt_evt_status = evt_status_ff;
    if (wr_en && hit(addr, uart_ier_pkg::evt_status_addr))
      nxt_evt_status = nxt_evt_status & ~wdata[4:0];
    nxt_evt_status = nxt_evt_status | rise;
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      src_prev_ff   <= 5'h00;
      evt_status_ff <= 5'h00;
      evt_mask_ff   <= 5'h00;
      event_irq     <= 1'b0;
    end
    else
    begin
      src_prev_ff   <= pending;
      evt_status_ff <= nxt_evt_status;
      if (wr_en && hit(addr, uart_ier_pkg::evt_mask_addr))
        evt_mask_ff <= wdata[4:0];
      event_irq <= |(nxt_evt_status & evt_mask_ff);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path; reserved bits return zero.
  always_comb
  begin
    nxt_rdata = 32'h00000000;
    if (hit(addr, uart_ier_pkg::ier_dlm_addr))
    begin
      if (divisor_latch_access_bit)
        nxt_rdata[7:0] = divisor_high_byte_ff;
      else
        nxt_rdata[9:0] = interrupt_source_enable_ff;
    end
    else if (hit(addr, uart_ier_pkg::dll_addr))
    begin
      if (divisor_latch_access_bit)
        nxt_rdata[7:0] = divisor_low_byte_ff;
    end
    else if (hit(addr, uart_ier_pkg::lcr_addr))
      nxt_rdata[7:0] = line_ctrl_ff;
    else if (hit(addr, uart_ier_pkg::fdr_addr))
      nxt_rdata[7:0] = {fractional_multiplier_ff, fractional_add_value_ff};
    else if (hit(addr, uart_ier_pkg::lsr_addr))
    begin
      nxt_rdata[uart_ier_pkg::lsr_transmit_holding_empty_bit] = transmit_holding_empty;
      nxt_rdata[uart_ier_pkg::lsr_err_hi:uart_ier_pkg::lsr_err_lo] =
        rx_line_errors;
      nxt_rdata[0] = receive_data_available;
    end
    else if (hit(addr, uart_ier_pkg::evt_status_addr))
      nxt_rdata[4:0] = evt_status_ff;
    else if (hit(addr, uart_ier_pkg::evt_mask_addr))
      nxt_rdata[4:0] = evt_mask_ff;
    else if (hit(addr, uart_ier_pkg::baud_cnt_addr))
      nxt_rdata[15:0] = tick_cnt_ff;
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
      rdata <= 32'h00000000;
    else if (rd_en)
      rdata <= nxt_rdata;
    else
      rdata <= 32'h00000000;
  end

  // The gated per-source vector is unused; it is only reduced here and does not feed the sticky mask path.
  logic unused_active;
  assign unused_active = |active;
endmodule
`default_nettype wire

/* File: tb/uart_ier_monitor.sv */
// Port-level checks of the interrupt enable block.
`default_nettype none
module uart_ier_monitor
(
  input wire logic        clk_sys,
  input wire logic        srst,
  input wire logic [31:0] addr,
  input wire logic [31:0] wdata,
  input wire logic        wr_en,
  input wire logic        rd_en,
  input wire logic [31:0] rdata,
  input wire logic        receive_data_available,
  input wire logic        char_timeout,
  input wire logic        transmit_holding_empty,
  input wire logic [3:0]  rx_line_errors,
  input wire logic        autobaud_timeout,
  input wire logic        autobaud_done,
  input wire logic        irq
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  logic       divisor_latch_access_bit_ff;
  logic [9:0] en_ff;
  logic [7:0] dlm_ff;
  logic [5:0] want;
  // Shadow copies of the access bit, enables and divisor high byte.
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      divisor_latch_access_bit_ff <= 1'b0;
      en_ff   <= 10'h000;
      dlm_ff  <= 8'h00;
    end
    else if (wr_en && addr == uart_ier_pkg::lcr_addr)
      divisor_latch_access_bit_ff <= wdata[uart_ier_pkg::divisor_latch_access_bit_bit];
    else if (wr_en && addr == uart_ier_pkg::ier_dlm_addr && divisor_latch_access_bit_ff)
      dlm_ff <= wdata[7:0];
    else if (wr_en && addr == uart_ier_pkg::ier_dlm_addr)
      en_ff <= wdata[9:0] & uart_ier_pkg::ier_valid_mask;
  end
  assign want = {autobaud_done & en_ff[9], autobaud_timeout & en_ff[8],
                 (|rx_line_errors) & en_ff[2],
                 transmit_holding_empty & en_ff[1],
                 char_timeout & en_ff[0], receive_data_available & en_ff[0]};
  sequence shared_rd_s;
    rd_en && addr == uart_ier_pkg::ier_dlm_addr;
  endsequence
  // The gate registers once, so irq follows the gated sources by one edge.
  rda_gate_a: assert property ($past(want[0]) |-> irq)
    else $error("irq missing for receive data");
  cto_gate_a: assert property ($past(want[1]) |-> irq)
    else $error("irq missing for character timeout");
  transmit_holding_empty_gate_a: assert property ($past(want[2]) |-> irq)
    else $error("irq missing for transmit empty");
  rls_gate_a: assert property ($past(want[3]) |-> irq)
    else $error("irq missing for line status");
  abto_gate_a: assert property ($past(want[4]) |-> irq)
    else $error("irq missing for autobaud timeout");
  abeo_gate_a: assert property ($past(want[5]) |-> irq)
    else $error("irq missing for autobaud done");
  irq_cause_a: assert property (irq |-> $past(|want))
    else $error("irq without enabled pending source");
  ier_read_a: assert property
    (shared_rd_s ##0 !divisor_latch_access_bit_ff |=> rdata == {22'h0, $past(en_ff)})
    else $error("enable register read wrong");
  dlm_read_a: assert property
    (shared_rd_s ##0 divisor_latch_access_bit_ff |=> rdata == {24'h0, $past(dlm_ff)})
    else $error("divisor high byte read wrong");
  rdata_idle_a: assert property (!rd_en |=> rdata == 32'h0)
    else $error("read data outside read cycle");
endmodule
bind uart_interrupt_enable uart_ier_monitor u_uart_ier_monitor
(
  .clk_sys(clk_sys), .srst(srst), .addr(addr), .wdata(wdata),
  .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .irq(irq),
  .receive_data_available(receive_data_available),
  .char_timeout(char_timeout), .rx_line_errors(rx_line_errors),
  .transmit_holding_empty(transmit_holding_empty),
  .autobaud_timeout(autobaud_timeout), .autobaud_done(autobaud_done)
);
`default_nettype wire

/* File: tb/source_model.sv */
// Receiver and transmitter side model driving the interrupt sources.
`default_nettype none
module source_model
(
  input  wire logic       clk_sys,
  input  wire logic [8:0] cmd,
  output var  logic [8:0] lines
);
  timeunit 1ns;
  timeprecision 1ps;
  // Sources are levels that change only after a clock edge.
  always_ff @(posedge clk_sys)
    lines <= cmd;
endmodule
`default_nettype wire

/* File: tb/test_uart_interrupt_enable.sv */
// Register-level bench for the interrupt enable block.
`default_nettype none
module test_uart_interrupt_enable;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] ier = uart_ier_pkg::ier_dlm_addr;
  logic        clk_sys = 1'b0;
  logic        srst = 1'b1;
  logic [31:0] addr = 32'h0;
  logic [31:0] wdata = 32'h0;
  logic        wr_en = 1'b0;
  logic        rd_en = 1'b0;
  logic [31:0] rdata;
  logic        irq;
  logic        event_irq;
  logic        tick;
  logic [8:0]  cmd = 9'h000;
  logic [8:0]  src;
  int          num_errors = 0;
  int          compares = 0;
  int          cyc = 0;
  int          n;
  int          m;
  logic [8:0]  src_t [6] = '{9'h001, 9'h002, 9'h004, 9'h040, 9'h080, 9'h100};
  logic [9:0]  ena_t [6] = '{10'h1, 10'h1, 10'h2, 10'h4, 10'h100, 10'h200};
  always #5 clk_sys = ~clk_sys;
  source_model u_source_model (.clk_sys(clk_sys), .cmd(cmd), .lines(src));
  uart_interrupt_enable u_uart_interrupt_enable
  (
    .clk_sys(clk_sys), .srst(srst), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
    .receive_data_available(src[0]), .char_timeout(src[1]),
    .transmit_holding_empty(src[2]), .rx_line_errors(src[6:3]),
    .autobaud_timeout(src[7]), .autobaud_done(src[8]),
    .irq(irq), .event_irq(event_irq), .baud_tick_16x(tick)
  );
  ////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    if (num_errors == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic wt(input int k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e)
    begin
      num_errors++;
      $display("Error at %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    addr  <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk_sys);
    wr_en <= 1'b0;
  endtask
  task automatic rdchk(input logic [31:0] a, input logic [31:0] e);
    @(posedge clk_sys);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge clk_sys);
    rd_en <= 1'b0;
    #1;
    chk(rdata, e);
  endtask
  // Cycles from one baud tick to the next.
  task automatic gap(output int p);
    p = 1;
    while (tick !== 1'b1) wt(1);
    wt(1);
    while (tick !== 1'b1)
    begin
      p++;
      wt(1);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      num_errors++;
      complete_run();
    end
  end
  initial
  begin
    wt(20);
    srst <= 1'b0;
    rdchk(ier, 32'h0);
    for (int k = 0; k < 6; k++)
    begin
      cmd <= src_t[k];
      wr(ier, {22'h0, uart_ier_pkg::ier_valid_mask & ~ena_t[k]});
      wt(4);
      chk(irq, 32'h0);
      wr(ier, {22'h0, uart_ier_pkg::ier_valid_mask});
      wt(4);
      chk(irq, 32'h1);
      cmd <= 9'h000;
      wt(4);
      chk(irq, 32'h0);
    end
    chk(event_irq, 32'h0);
    wr(uart_ier_pkg::evt_mask_addr, 32'h1f);
    wt(2);
    chk(event_irq, 32'h1);
    wr(uart_ier_pkg::evt_status_addr, 32'h1f);
    wt(2);
    chk(event_irq, 32'h0);
    wr(uart_ier_pkg::lcr_addr, 32'h83);
    rdchk(ier, 32'h0);
    wr(ier, 32'h01);
    wr(uart_ier_pkg::dll_addr, 32'h0);
    rdchk(ier, 32'h01);
    wr(uart_ier_pkg::lcr_addr, 32'h03);
    rdchk(ier, 32'h307);
    gap(n);
    gap(n);
    chk(n, 32'd256);
    wr(uart_ier_pkg::fdr_addr, 32'h11);
    gap(n);
    gap(n);
    gap(m);
    chk(n + m, 32'd1024);
    srst <= 1'b1;
    wt(3);
    srst <= 1'b0;
    rdchk(ier, 32'h0);
    rdchk(32'he000c0fc, 32'h0);
    complete_run();
  end
endmodule
`default_nettype wire
